// *** shplc_pkg.sv ***
// Purpose: Shared constants and types for the serial host port.
// Assumes: One system clock of 10 MHz at both ends.
// Notes: Frame is 16 bits, LSB first: R/W, 7 address, 8 data.
package shplc_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 100; // System clock period in ns
  localparam int MRST_US = 10; // Least master reset low time in us
  localparam int MRST_CYC = (MRST_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int MRST_HOLD_CYC = 2 * MRST_CYC; // Host hold margin
  localparam int SCLK_HALF = 8; // System cycles per serial half period
  ////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int XFER_BITS = 16; // Serial clocks per transaction
  localparam int HDR_BITS = 8; // R/W plus address
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int ALARM_W = 8;
  localparam int LOOP_W = 5;
  ////////////////////////////////////////////////////////////////////////
  // Device registers
  localparam logic [6:0] DREG_CTRL = 7'h00; // Loop selects, flush
  localparam logic [6:0] DREG_ALARM = 7'h01; // Alarm status, read acks
  localparam logic [7:0] CTRL_RST = 8'h00; // All modes disabled
  localparam int CB_SRL = 0; // Serial remote loopback
  localparam int CB_PRL = 1; // Parallel remote loopback
  localparam int CB_LDL = 2; // Local digital loopback
  localparam int CB_LTJ = 3; // Line timed, dejittered
  localparam int CB_LTD = 4; // Line timed, direct
  localparam int CB_DIV32 = 5; // Direct line timing divides by 32
  localparam int CB_FLUSH = 6; // Transmit FIFO flush, self clearing
  localparam logic [7:0] CTRL_MASK = 8'h3F; // Stored control bits
  ////////////////////////////////////////////////////////////////////////
  // Host controller registers
  localparam int HBUS_AW = 2;
  localparam int HBUS_DW = 16;
  localparam logic [1:0] HREG_CMD = 2'h0; // Write starts a transfer
  localparam logic [1:0] HREG_STAT = 2'h1; // Busy, interrupt, read data
  localparam logic [1:0] HREG_PINS = 2'h2; // Strap and mode pins
  localparam int HC_READ = 7; // CMD: read when set
  localparam int HC_WDATA = 8; // CMD: write data low bit
  localparam int HS_BUSY = 0;
  localparam int HS_INT = 1;
  localparam int HS_RDATA = 8;
  localparam int HP_PATH = 0; // PINS: control path select
  localparam int HP_LOOP = 1; // PINS: loop pins low bit
  localparam int HP_MRST = 6; // PINS: pulse a master reset
  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SHPLC_TX_NORMAL = 2'b00, // Serializer from parallel input
    SHPLC_TX_RX_SERIAL = 2'b01, // Receive serial looped straight back
    SHPLC_TX_RX_PAR = 2'b10 // Recovered data looped at parallel side
  } shplc_txsrc_t;
  typedef enum logic [1:0] {
    SHPLC_H_IDLE = 2'b00,
    SHPLC_H_SETUP = 2'b01,
    SHPLC_H_SHIFT = 2'b10,
    SHPLC_H_GAP = 2'b11
  } shplc_hstate_t;
endpackage

// *** shplc_if.sv ***
// Purpose: Pins between the host processor and the transceiver.
// Assumes: Interrupt line has a pull-up; mode pins have pull-downs.
// Notes: Open-drain interrupt resolved here from the enable.
`timescale 1ns/1ps
interface shplc_if;
  logic cs_n; // Chip select, active low
  logic sclk; // Serial clock from host
  logic serial_port_in; // Host to device data
  logic serial_port_out; // Device to host data
  logic int_o; // Device interrupt drive value
  logic int_oe; // Device interrupt drive enable
  logic int_n; // Resolved interrupt line
  logic reset_n; // Master reset, active low
  logic control_path_select; // High selects host register path
  logic [4:0] loop_pins; // Hardware mode loop pins
  // Pull-up when nobody drives
  assign int_n = int_oe ? int_o : 1'b1;
  modport dev (input cs_n, sclk, serial_port_in, reset_n,
    control_path_select, loop_pins, output serial_port_out, int_o, int_oe);
  modport host (output cs_n, sclk, serial_port_in, reset_n,
    control_path_select, loop_pins, input serial_port_out, int_n);
endinterface

// *** shplc_dev.sv ***
// Purpose: Device end: serial register port, interrupt, loop control.
// Assumes: Pins are asynchronous to clk_sys; alarm_in is on clk_sys.
// Notes: Serial clock is oversampled, so it must be slow vs clk_sys.
// Notes on behaviour
// - Strap high selects registers, low selects pins
// - Chip select low enables port, high disables
// - Host deasserts select between single transfers
// - A transfer is exactly sixteen serial clocks
// - Data in sampled on serial clock rise
// - Read data changes on falls eight-fifteen, bit0 first
// - Host captures read data on rises nine-sixteen
// - Alarm change drives open-drain interrupt low in host mode only
// - Reading alarm status releases the interrupt
// - Reset pin low over 10us restores defaults
// - Serial remote loop: receive serial to transmit
// - Parallel remote loop: recovered data to transmit
// - Host avoids other loops during parallel remote
// - Host flushes FIFO when parallel remote toggles
// - Local loop: parallel transmit to parallel receive
// - Local and serial remote loops may coexist
// - Dejittered line timing uses recovered clock reference
// - Direct line timing: multiplier uses divided recovered clock; cmu_ref_div32 only follows control bit 5, in host mode only
`timescale 1ns/1ps
module shplc_dev
  import shplc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  shplc_if.dev link,
  input wire logic [ALARM_W-1:0] alarm_in,
  output logic host_mode,
  output logic serial_remote_loopback,
  output logic parallel_remote_loopback,
  output logic local_digital_loopback,
  output logic line_timed_dejittered,
  output logic line_timed_direct,
  output logic cmu_ref_div32,
  output shplc_txsrc_t tx_serial_src,
  output logic rx_par_from_tx,
  output logic rx_serial_ignored,
  output logic fifo_flush
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SYN_W = 10;
  logic [SYN_W-1:0] pins_raw; // Raw asynchronous pins
  logic [SYN_W-1:0] s1_q; // First stage, read only by s2_q
  logic [SYN_W-1:0] s2_q; // Second stage, safe to use
  logic sclk_s3_q; // Delayed serial clock for edges
  logic cs_act; // Chip select low
  logic sclk_rise;
  logic sclk_fall;
  logic sdi_s;
  logic rst_pin_low;
  logic path_s;
  logic [LOOP_W-1:0] loop_s;

  assign pins_raw = {link.reset_n, link.control_path_select,
    link.loop_pins, link.cs_n, link.sclk, link.serial_port_in};
  assign rst_pin_low = ~s2_q[9];
  assign path_s = s2_q[8];
  assign loop_s = s2_q[7:3];
  assign cs_act = ~s2_q[2];
  assign sdi_s = s2_q[0];

  // Two flops on every pin
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 10'h204; // Reset and chip select idle high, path low
      s2_q <= 10'h204;
      sclk_s3_q <= 1'b0;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      sclk_s3_q <= s2_q[1];
    end
  end
  assign sclk_rise = s2_q[1] & ~sclk_s3_q;
  assign sclk_fall = ~s2_q[1] & sclk_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Master reset filter
  logic [7:0] mrst_cnt_q; // Cycles the reset pin has been low
  logic mrst; // Pin low for longer than the least time

  // Count low time, saturate at the limit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mrst_cnt_q <= 8'h00;
    end else if (!rst_pin_low) begin
      mrst_cnt_q <= 8'h00;
    end else if (mrst_cnt_q != 8'(MRST_CYC)) begin
      mrst_cnt_q <= mrst_cnt_q + 8'h01;
    end
  end
  assign mrst = (mrst_cnt_q == 8'(MRST_CYC));

  ////////////////////////////////////////////////////////////////////////
  // Serial frame engine
  logic [4:0] cnt_q; // Rising serial edges since select fell
  logic [15:0] shin_q; // Incoming bits, LSB first from the top
  logic [7:0] rdsh_q; // Outgoing read data
  logic rd_act_q; // Current frame is a read
  logic sdo_q;
  logic hdr_done; // Eighth rise seen
  logic last_rise; // Sixteenth rise seen
  logic [6:0] hdr_addr;
  logic wr_commit;
  logic rd_alarm; // Read of alarm status starting
  logic [7:0] ctrl_q;
  logic [7:0] rd_mux;

  assign hdr_done = cs_act & sclk_rise & (cnt_q == 5'(HDR_BITS - 1));
  assign last_rise = cs_act & sclk_rise & (cnt_q == 5'(XFER_BITS - 1));
  assign hdr_addr = {sdi_s, shin_q[15:10]};
  assign wr_commit = last_rise & ~shin_q[1] & ~mrst;
  assign rd_alarm = hdr_done & shin_q[9] & (hdr_addr == DREG_ALARM);

  // Read data selection
  always_comb begin
    rd_mux = 8'h00; // Unmapped reads zero
    if (hdr_addr == DREG_CTRL) begin
      rd_mux = ctrl_q;
    end else if (hdr_addr == DREG_ALARM) begin
      rd_mux = alarm_in;
    end
  end

  // Edge count, cleared whenever select is high
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 5'h00;
    end else if (!cs_act || mrst) begin
      cnt_q <= 5'h00;
    end else if (sclk_rise && cnt_q != 5'(XFER_BITS + 1)) begin
      cnt_q <= cnt_q + 5'h01; // Overlong frames stick at 17
    end
  end

  // Shift in on each rise while selected
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shin_q <= 16'h0000;
    end else if (cs_act && sclk_rise) begin
      shin_q <= {sdi_s, shin_q[15:1]};
    end
  end

  // Read launch and output shifting
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_act_q <= 1'b0;
      rdsh_q <= 8'h00;
      sdo_q <= 1'b0;
    end else if (!cs_act || mrst) begin
      rd_act_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (hdr_done) begin
      rd_act_q <= shin_q[9]; // First bit set means read
      rdsh_q <= rd_mux;
    end else if (sclk_fall && rd_act_q && cnt_q >= 5'(HDR_BITS)
        && cnt_q < 5'(XFER_BITS)) begin
      sdo_q <= rdsh_q[0]; // Bit 0 on fall of clock eight
      rdsh_q <= {1'b0, rdsh_q[7:1]};
    end
  end
  assign link.serial_port_out = sdo_q;

  ////////////////////////////////////////////////////////////////////////
  // Control register
  logic flush_q;

  // Written on the sixteenth rise; defaults on long reset pin
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      flush_q <= 1'b0;
    end else if (mrst) begin
      ctrl_q <= CTRL_RST;
      flush_q <= 1'b0;
    end else begin
      flush_q <= 1'b0;
      if (wr_commit && shin_q[8:2] == DREG_CTRL) begin
        ctrl_q <= {sdi_s, shin_q[15:9]} & CTRL_MASK;
        flush_q <= shin_q[9 + CB_FLUSH]; // Host flush request
      end
    end
  end
  assign fifo_flush = flush_q;

  ////////////////////////////////////////////////////////////////////////
  // Alarm interrupt
  logic [ALARM_W-1:0] alarm_q; // Previous alarm status
  logic int_pend_q;
  logic int_oe_q;

  // Set on change, cleared by status read; set wins
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_q <= '0;
      int_pend_q <= 1'b0;
      int_oe_q <= 1'b0;
    end else begin
      alarm_q <= alarm_in;
      if (alarm_in != alarm_q) begin
        int_pend_q <= 1'b1;
      end else if (rd_alarm || mrst) begin
        int_pend_q <= 1'b0;
      end
      int_oe_q <= int_pend_q & path_s; // Host mode only
    end
  end
  assign link.int_o = 1'b0; // Only ever pulls low
  assign link.int_oe = int_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Mode selection and datapath steering
  logic [LOOP_W-1:0] mode; // Effective loop selections

  // Registers in host mode, pins in hardware mode
  assign mode = path_s ? ctrl_q[LOOP_W-1:0] : loop_s;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      host_mode <= 1'b0;
      serial_remote_loopback <= 1'b0;
      parallel_remote_loopback <= 1'b0;
      local_digital_loopback <= 1'b0;
      line_timed_dejittered <= 1'b0;
      line_timed_direct <= 1'b0;
      cmu_ref_div32 <= 1'b0;
      tx_serial_src <= SHPLC_TX_NORMAL;
      rx_par_from_tx <= 1'b0;
      rx_serial_ignored <= 1'b0;
    end else begin
      host_mode <= path_s;
      serial_remote_loopback <= mode[CB_SRL];
      parallel_remote_loopback <= mode[CB_PRL];
      local_digital_loopback <= mode[CB_LDL];
      line_timed_dejittered <= mode[CB_LTJ];
      line_timed_direct <= mode[CB_LTD];
      cmu_ref_div32 <= path_s & ctrl_q[CB_DIV32];
      if (mode[CB_PRL]) begin
        tx_serial_src <= SHPLC_TX_RX_PAR; // Wins if misused
      end else if (mode[CB_SRL]) begin
        tx_serial_src <= SHPLC_TX_RX_SERIAL;
      end else begin
        tx_serial_src <= SHPLC_TX_NORMAL;
      end
      // Local loop works alongside serial remote
      rx_par_from_tx <= mode[CB_LDL];
      rx_serial_ignored <= mode[CB_LDL];
    end
  end
endmodule

// *** shplc_host.sv ***
// Purpose: Host end: drives serial frames, straps and reset pins.
// Assumes: Software uses a plain strobe port, read data next cycle.
// Notes: Serial clock is clk_sys divided by 2*SCLK_HALF.
`timescale 1ns/1ps
module shplc_host
  import shplc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  shplc_if.host link,
  input wire logic [HBUS_AW-1:0] bus_addr,
  input wire logic [HBUS_DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [HBUS_DW-1:0] bus_rdata,
  output logic xfer_done,
  output logic irq_pending
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] s1_q; // First stage, read only by s2_q
  logic [1:0] s2_q; // {interrupt line, serial data out}

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 2'h2;
      s2_q <= 2'h2;
    end else begin
      s1_q <= {link.int_n, link.serial_port_out};
      s2_q <= s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin register and reset pulse
  logic path_q;
  logic [LOOP_W-1:0] loops_q;
  logic [7:0] mrst_cnt_q; // Cycles left with reset low
  logic reset_n_q;

  // Straps default to hardware mode, loops off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      path_q <= 1'b0;
      loops_q <= '0;
    end else if (bus_wr && bus_addr == HREG_PINS) begin
      path_q <= bus_wdata[HP_PATH];
      loops_q <= bus_wdata[HP_LOOP +: LOOP_W];
    end
  end

  // Hold reset low longer than the least time
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mrst_cnt_q <= 8'h00;
      reset_n_q <= 1'b1;
    end else begin
      if (bus_wr && bus_addr == HREG_PINS && bus_wdata[HP_MRST]) begin
        mrst_cnt_q <= 8'(MRST_HOLD_CYC);
      end else if (mrst_cnt_q != 8'h00) begin
        mrst_cnt_q <= mrst_cnt_q - 8'h01;
      end
      reset_n_q <= (mrst_cnt_q == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  shplc_hstate_t st_q;
  logic [3:0] ph_q; // Phase within a serial half period
  logic [4:0] k_q; // Rising edges issued
  logic [15:0] tx_q; // Outgoing frame, LSB first
  logic [7:0] rx_q; // Captured read data
  logic [7:0] rdata_q;
  logic is_rd_q;
  logic cs_n_q;
  logic sclk_q;
  logic sdi_q;
  logic done_q;
  logic tick;
  logic start;

  assign tick = (ph_q == 4'(SCLK_HALF - 1));
  assign start = bus_wr && bus_addr == HREG_CMD && st_q == SHPLC_H_IDLE;

  // Half period divider
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q <= 4'h0;
    end else if (st_q == SHPLC_H_IDLE || tick) begin
      ph_q <= 4'h0;
    end else begin
      ph_q <= ph_q + 4'h1;
    end
  end

  // One single frame per select, then a gap
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= SHPLC_H_IDLE;
      k_q <= 5'h00;
      tx_q <= 16'h0000;
      rx_q <= 8'h00;
      rdata_q <= 8'h00;
      is_rd_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sdi_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        SHPLC_H_IDLE: begin
          if (start) begin
            // Header then data
            // Read flag leaves first, then address, then data
            tx_q <= {bus_wdata[HC_WDATA +: DATA_W],
              bus_wdata[ADDR_W-1:0], bus_wdata[HC_READ]};
            is_rd_q <= bus_wdata[HC_READ];
            sdi_q <= bus_wdata[HC_READ];
            cs_n_q <= 1'b0;
            k_q <= 5'h00;
            st_q <= SHPLC_H_SETUP;
          end
        end
        SHPLC_H_SETUP: begin
          if (tick) begin
            sclk_q <= 1'b1;
            k_q <= 5'h01;
            st_q <= SHPLC_H_SHIFT;
          end
        end
        SHPLC_H_SHIFT: begin
          if (tick && sclk_q) begin
            sclk_q <= 1'b0;
            if (k_q == 5'(XFER_BITS)) begin
              cs_n_q <= 1'b1; // Sixteen clocks done
              st_q <= SHPLC_H_GAP;
            end else begin
              tx_q <= {1'b0, tx_q[15:1]};
              sdi_q <= tx_q[1];
            end
          end else if (tick) begin
            sclk_q <= 1'b1;
            k_q <= k_q + 5'h01;
            if (is_rd_q && k_q >= 5'(HDR_BITS)) begin
              rx_q <= {s2_q[0], rx_q[7:1]}; // Rises 9 to 16
            end
          end
        end
        SHPLC_H_GAP: begin
          if (tick) begin
            if (is_rd_q) begin
              rdata_q <= rx_q;
            end
            done_q <= 1'b1;
            st_q <= SHPLC_H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.serial_port_in = sdi_q;
  assign link.reset_n = reset_n_q;
  assign link.control_path_select = path_q;
  assign link.loop_pins = loops_q;

  ////////////////////////////////////////////////////////////////////////
  // Status read port and outputs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bus_rdata <= 16'h0000;
      xfer_done <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      xfer_done <= done_q;
      irq_pending <= ~s2_q[1];
      bus_rdata <= 16'h0000; // Unmapped or idle reads zero
      if (bus_rd && bus_addr == HREG_STAT) begin
        bus_rdata[HS_BUSY] <= (st_q != SHPLC_H_IDLE);
        bus_rdata[HS_INT] <= ~s2_q[1];
        bus_rdata[HS_RDATA +: DATA_W] <= rdata_q;
      end else if (bus_rd && bus_addr == HREG_PINS) begin
        bus_rdata[HP_PATH] <= path_q;
        bus_rdata[HP_LOOP +: LOOP_W] <= loops_q;
      end
    end
  end
endmodule

// *** shplc_chk.sv ***
// Purpose: Watches the serial pins between host and device ends.
// Assumes: One clk_sys domain; sys_rst async, active high.
// Notes: Instantiated beside the interface, no bind.
`timescale 1ns/1ps
module shplc_chk
  import shplc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_port_in,
  input wire logic serial_port_out,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic int_n,
  input wire logic reset_n,
  input wire logic control_path_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  logic sclk_q; // Serial clock one cycle back
  logic [4:0] rises_q; // Serial clock rises in this frame
  // Count rises while selected, clear when deselected
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rises_q <= 5'h00;
      end else if (sclk && !sclk_q) begin
        rises_q <= rises_q + 5'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_frame_len: assert property ($rose(cs_n) |-> rises_q == 5'h10)
    else $error("frame did not hold sixteen serial clocks");
  a_setup_gap: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
    else $error("first serial clock out of place");
  a_sclk_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase wrong");
  a_sdi_hold: assert property (sclk |-> $stable(serial_port_in))
    else $error("data in moved while serial clock high");
  a_sdo_steady: assert property (sclk && !cs_n |->
    $stable(serial_port_out))
    else $error("data out moved while serial clock high");
  a_sdo_quiet: assert property (cs_n [*5] |-> !serial_port_out)
    else $error("data out driven while deselected");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("chip select gap too short");
  a_int_level: assert property (int_oe |->
    !int_o && !int_n && $past(control_path_select, 3))
    else $error("interrupt driven outside host mode or not low");
  a_mrst_len: assert property ($fell(reset_n) |->
    ##150 !reset_n ##[40:60] reset_n)
    else $error("master reset pulse length wrong");
endmodule

// *** shplc_tb.sv ***
// Purpose: Self-checking bench joining host and device ends.
// Assumes: clk_sys at 10 MHz; sys_rst held 16 cycles.
// Notes: All frames start from the software port of the host end.
`timescale 1ns/1ps
module shplc_tb
  import shplc_pkg::*;
;
  logic clk_sys = 1'b0; // System clock
  logic sys_rst = 1'b1; // Reset, active high
  logic [1:0] bus_addr = 2'h0; // Software port
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic xfer_done, irq_pending;
  logic [7:0] alarm_in = 8'h00; // Alarm status
  logic host_mode, serial_remote_loopback, parallel_remote_loopback;
  logic local_digital_loopback, line_timed_dejittered, line_timed_direct;
  logic cmu_ref_div32, rx_par_from_tx, rx_serial_ignored, fifo_flush;
  shplc_txsrc_t tx_serial_src; // Transmit source
  logic [5:0] modes; // Modes in control bit order
  int num_errors = 0;
  int num_checks = 0;
  int flushes = 0; // Flush pulses seen
  assign modes = {cmu_ref_div32, line_timed_direct, line_timed_dejittered,
    local_digital_loopback, parallel_remote_loopback, serial_remote_loopback};
  shplc_if link_if();
  shplc_dev shplc_dev_inst(.clk_sys, .sys_rst, .link(link_if), .alarm_in,
    .host_mode, .serial_remote_loopback, .parallel_remote_loopback,
    .local_digital_loopback, .line_timed_dejittered, .line_timed_direct,
    .cmu_ref_div32, .tx_serial_src, .rx_par_from_tx, .rx_serial_ignored,
    .fifo_flush);
  shplc_host shplc_host_inst(.clk_sys, .sys_rst, .link(link_if), .bus_addr,
    .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .xfer_done, .irq_pending);
  shplc_chk shplc_chk_inst(.clk_sys, .sys_rst, .cs_n(link_if.cs_n),
    .sclk(link_if.sclk), .serial_port_in(link_if.serial_port_in),
    .serial_port_out(link_if.serial_port_out), .int_o(link_if.int_o),
    .int_oe(link_if.int_oe), .int_n(link_if.int_n),
    .reset_n(link_if.reset_n),
    .control_path_select(link_if.control_path_select));
  ////////////////////////////////////////////////////////////////////////
  // Clock and flush pulse counter
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (fifo_flush === 1'b1) flushes <= flushes + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Wait n edges, then settle to the falling edge
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the next cycle
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(negedge clk_sys);
    d = bus_rdata;
  endtask
  // One serial frame; returns the byte read back
  task automatic xfer(input logic [15:0] cmd, output logic [7:0] d);
    logic [15:0] s;
    int i;
    wr(HREG_CMD, cmd);
    for (i = 0; i < 600 && xfer_done !== 1'b1; i++) @(negedge clk_sys);
    chk(i < 600, 1'b1);
    rd(HREG_STAT, s);
    chk(s[HS_INT:HS_BUSY], 2'h0);
    d = s[15:8];
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Defaults after reset
  task automatic t_reset;
    logic [15:0] s;
    chk({host_mode, modes}, 7'h00);
    chk(link_if.int_n, 1'b1);
    rd(2'h3, s);
    chk(s, 16'h0000);
    $display("Test reset done");
  endtask
  // Each mode pin alone, then dual loopback, hardware path
  task automatic t_pins;
    logic [15:0] s;
    for (int i = 0; i < LOOP_W; i++) begin
      wr(HREG_PINS, 16'(2 << i));
      idle(8);
      chk(modes, 6'(1 << i));
      chk(tx_serial_src, i == CB_SRL ? SHPLC_TX_RX_SERIAL :
        i == CB_PRL ? SHPLC_TX_RX_PAR : SHPLC_TX_NORMAL);
      chk(rx_par_from_tx, i == CB_LDL);
    end
    wr(HREG_PINS, 16'h000A);
    idle(8);
    chk({host_mode, modes}, 7'h05);
    chk({rx_serial_ignored, tx_serial_src}, 3'h5);
    rd(HREG_PINS, s);
    chk(s, 16'h000A);
    $display("Test pins done");
  endtask
  // Register path: pins ignored, write and read back control
  task automatic t_host;
    logic [7:0] d;
    wr(HREG_PINS, 16'h0005);
    idle(8);
    chk({host_mode, modes}, 7'h40);
    xfer({8'h35, 1'b0, DREG_CTRL}, d);
    idle(4);
    chk(modes, 6'h35);
    xfer({8'h00, 1'b1, DREG_CTRL}, d);
    chk(d, 8'h35);
    xfer({8'h42, 1'b0, DREG_CTRL}, d);
    idle(4);
    chk(tx_serial_src, SHPLC_TX_RX_PAR);
    chk(16'(flushes), 16'h0001);
    xfer({8'h00, 1'b1, DREG_CTRL}, d);
    chk(d, 8'h02);
    $display("Test host done");
  endtask
  // Alarm change pulls interrupt, status read releases it
  task automatic t_alarm;
    logic [7:0] d;
    @(posedge clk_sys);
    alarm_in <= 8'h5A;
    idle(10);
    chk(link_if.int_n, 1'b0);
    chk(irq_pending, 1'b1);
    xfer({8'h00, 1'b1, DREG_ALARM}, d);
    chk(d, 8'h5A);
    idle(6);
    chk(link_if.int_n, 1'b1);
    $display("Test alarm done");
  endtask
  // Master reset: not before the limit, defaults after it
  task automatic t_mrst;
    logic [7:0] d;
    wr(HREG_PINS, 16'h0041);
    idle(60);
    chk(modes, 6'h02);
    idle(200);
    chk(modes, 6'h00);
    xfer({8'h00, 1'b1, DREG_CTRL}, d);
    chk(d, 8'h00);
    $display("Test master reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    #4000000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    idle(4);
    t_reset();
    t_pins();
    t_host();
    t_alarm();
    t_mrst();
    give_verdict();
  end
endmodule
